/* pkg/rmx_pkg.sv */
// real-mode execution control: constants, types and operation list
// assumes one 40 MHz clock and an asynchronous active-low reset
//
// Operation
// (RQ1) after reset the core starts in real mode
// (RQ2) default operand size is 16 bits; override prefix selects 32
// (RQ3) physical address is segment shifted left four plus effective address
// (RQ4) segments are 64K; offset past FFFFH, including wrapped word, gives 13
// (RQ5) address lines 2..19 active; upper lines high until first far transfer; code also drives line 20 and forces 31..20 high only for code fetches
// (RQ6) lock accepted only on listed read-modify-write memory destination forms
// (RQ7) lock on any other form raises exception 6
// (RQ8) lock legality ignores io privilege level; locked op is indivisible
// (RQ9) memory 0..3FFH holds the 256-entry four-byte vector table
// (RQ10) real mode never raises exceptions 10, 11 or 14
// (RQ11) halt stops bus use; nmi, enabled maskable interrupt or reset resume
// (RQ12) interrupt ending halt saves address of instruction after halt
// (RQ13) exception 8, 13 or interrupt beyond table limit causes shutdown
// (RQ14) call, int or push wrapping stack with odd pointer causes shutdown
// (RQ15) nmi leaves shutdown only if limit >= 17H and pointer > 5H
// (RQ16) stack reference past FFFFH raises 12 as a fault
// (RQ17) vector outside table limit raises 8 as a fault
// (RQ18) exceptions leave as 8-bit vector plus fault or trap flag
package rmx_pkg;

  localparam logic [7:0] RMX_VEC_UD = 8'h06;
  localparam logic [7:0] RMX_VEC_DF = 8'h08;
  localparam logic [7:0] RMX_VEC_SS = 8'h0C;
  localparam logic [7:0] RMX_VEC_GP = 8'h0D;
  localparam logic [7:0] RMX_VEC_NMI = 8'h02;
  localparam logic [15:0] RMX_SEG_MAX = 16'hFFFF;
  localparam logic [15:0] RMX_NMI_LIMIT_MIN = 16'h0017;
  localparam logic [15:0] RMX_NMI_SP_MIN = 16'h0005;
  localparam int RMX_SEG_SHIFT = 4;
  localparam int RMX_PA_W = 32;
  localparam logic [15:0] RMX_IVT_LIMIT_RST = 16'h03FF;
  localparam logic [15:0] RMX_IVT_ENTRY_BYTES = 16'h0004;

  // instruction classes seen by the decoder for the lock check
  typedef enum logic [3:0] {
    RMX_OP_OTHER,
    RMX_OP_BT_MOD,
    RMX_OP_EXCHANGE,
    RMX_OP_ALU,
    RMX_OP_UNARY,
    RMX_OP_STRING
  } rmx_op_e;

  typedef enum logic [1:0] {
    RMX_ST_RUN,
    RMX_ST_HALT,
    RMX_ST_SHUT
  } rmx_mode_e;

  typedef struct packed {
    logic [15:0] seg;
    logic [31:0] ea;
    logic [1:0] size_m1;
    logic is_stack;
    logic is_code;
  } rmx_ref_s;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic fault;
  } rmx_exc_s;

endpackage : rmx_pkg

/* rtl/rmx_addr_gen.sv */
// real-mode address former and segment limit check
// assumes references come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module rmx_addr_gen
  import rmx_pkg::*;
(
  // reference
  input wire rmx_ref_s ref_i,
  input wire logic far_seen_i,
  // result
  output logic [RMX_PA_W-1:0] phys_o,
  output logic overrun_o
);
  logic [32:0] last_byte;
  logic [20:0] lin;

  always_comb begin
    // wide sum so a word at FFFFH is caught rather than wrapped
    last_byte = {1'b0, ref_i.ea} + {31'h0, ref_i.size_m1};
    overrun_o = |last_byte[32:16]; // RQ4 RQ16
    lin = {1'b0, ref_i.seg, 4'h0} + {5'h00, ref_i.ea[15:0]}; // RQ3
    phys_o = {11'h000, lin};
    // code fetches keep the top lines high until a far transfer
    if (ref_i.is_code && !far_seen_i) begin
      phys_o[31:20] = 12'hFFF; // RQ5
    end else begin
      phys_o[31:20] = {11'h000, lin[20]}; // RQ5
    end
  end
endmodule : rmx_addr_gen
`default_nettype wire

/* rtl/rmx_ctrl.sv */
// real-mode execution control: halt, shutdown, lock check, exceptions
// assumes decoder and bus unit on the same clock; pins are synchronised here
`timescale 1ns/100ps
`default_nettype none
module rmx_ctrl
  import rmx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire logic halt_instruction_i,
  input wire logic far_transfer_i,
  input wire logic lock_prefix_i,
  input wire rmx_op_e op_class_i,
  input wire logic mem_dest_i,
  input wire logic opsize_override_i,
  input wire logic [1:0] io_privilege_level_i,
  // memory reference
  input wire logic ref_valid_i,
  input wire rmx_ref_s ref_i,
  // interrupt request
  input wire logic soft_int_i,
  input wire logic [7:0] soft_vec_i,
  input wire logic stack_push_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic [15:0] ivt_limit_i,
  input wire logic if_flag_i,
  // pins
  input wire logic nmi_i,
  input wire logic maskable_interrupt_request_i,
  // outputs
  output logic real_mode_o,
  output logic op32_o,
  output logic [RMX_PA_W-1:0] phys_addr_o,
  output logic bus_enable_o,
  output logic bus_lock_o,
  output rmx_exc_s exc_o,
  output logic resume_after_halt_o,
  output logic halted_o,
  output logic shutdown_o
);
  typedef struct packed {
    logic [2:0] nmi_sy;
    logic [2:0] irq_sy;
    logic nmi_lvl;
    logic irq_lvl;
    rmx_mode_e mode;
    logic far_seen;
    logic resume;
    logic [RMX_PA_W-1:0] phys;
    rmx_exc_s exc;
  } rmx_state_s;

  rmx_state_s q, d;
  logic [RMX_PA_W-1:0] phys_c;
  logic overrun;
  logic nmi_rise;
  logic lock_ok;
  logic [7:0] exc_vec;
  logic exc_raise;
  logic vec_beyond;
  logic halt_wake;
  logic shut_wake;

  rmx_addr_gen u_addr (
    .ref_i(ref_i),
    .far_seen_i(q.far_seen),
    .phys_o(phys_c),
    .overrun_o(overrun)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic vec_in_table(input logic [7:0] v,
                                        input logic [15:0] lim);
    logic [17:0] top;
    top = {8'h00, v, 2'b11};
    vec_in_table = top <= {2'b00, lim};
  endfunction : vec_in_table

  // a level moves only once the last two stages agree
  function automatic logic sync_level(input logic [2:0] sy,
                                      input logic lvl);
    sync_level = (sy[1] == sy[2]) ? sy[2] : lvl;
  endfunction : sync_level

  // exchange always has a memory side; bit-test, alu and unary forms must write memory
  // so that the locked cycles form one read-modify-write
  function automatic logic lock_legal(input rmx_op_e op,
                                      input logic md);
    unique case (op)
      RMX_OP_EXCHANGE: lock_legal = 1'b1;
      RMX_OP_BT_MOD, RMX_OP_ALU, RMX_OP_UNARY: lock_legal = md;
      default: lock_legal = 1'b0;
    endcase
  endfunction : lock_legal

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    d = q;
    d.nmi_sy = {q.nmi_sy[1:0], nmi_i};
    d.irq_sy = {q.irq_sy[1:0], maskable_interrupt_request_i};
    d.nmi_lvl = sync_level(q.nmi_sy, q.nmi_lvl);
    d.irq_lvl = sync_level(q.irq_sy, q.irq_lvl);
    nmi_rise = d.nmi_lvl && !q.nmi_lvl;
    // maskable requests are levels, gated by the enable flag
    halt_wake = nmi_rise || (d.irq_lvl && if_flag_i); // RQ11
    // nmi needs its vector in the table and room on the stack
    shut_wake = nmi_rise && ivt_limit_i >= RMX_NMI_LIMIT_MIN &&
                stack_pointer_i > RMX_NMI_SP_MIN; // RQ15
    // io privilege level deliberately not consulted
    lock_ok = lock_legal(op_class_i, mem_dest_i); // RQ6 RQ8
    exc_raise = 1'b0;
    exc_vec = RMX_VEC_GP;
    vec_beyond = 1'b0;
    d.exc = '0;
    d.resume = 1'b0;
    // instruction, reference, software interrupt and push requests are ignored in halt and shutdown
    unique case (q.mode)
      RMX_ST_RUN: begin
        if (instr_valid_i && lock_prefix_i && !lock_ok) begin
          exc_raise = 1'b1; // RQ7
          exc_vec = RMX_VEC_UD;
        end else if (ref_valid_i && overrun) begin
          exc_raise = 1'b1;
          exc_vec = ref_i.is_stack ? RMX_VEC_SS : RMX_VEC_GP; // RQ4 RQ16
        end else if (soft_int_i &&
                     !vec_in_table(soft_vec_i, ivt_limit_i)) begin
          exc_raise = 1'b1; // RQ17
          exc_vec = RMX_VEC_DF;
        end
        vec_beyond = !vec_in_table(exc_vec, ivt_limit_i);
        if (stack_push_i && stack_pointer_i == 16'h0001) begin
          d.mode = RMX_ST_SHUT; // RQ14
        end else if (exc_raise && (exc_vec == RMX_VEC_DF ||
                     exc_vec == RMX_VEC_GP) && vec_beyond) begin
          d.mode = RMX_ST_SHUT; // RQ13
        end else if (exc_raise) begin
          // only 6, 8, 12, 13 come from here, never 10, 11 or 14
          d.exc.valid = 1'b1; // RQ10 RQ18
          d.exc.vector = exc_vec;
          // fault: saved address stays on the failing instruction
          d.exc.fault = 1'b1;
        end else if (instr_valid_i && halt_instruction_i) begin
          d.mode = RMX_ST_HALT; // RQ11
        end
        if (instr_valid_i && far_transfer_i) begin
          d.far_seen = 1'b1; // RQ5
        end
        if (ref_valid_i) begin
          d.phys = phys_c; // RQ3
        end
      end
      RMX_ST_HALT: begin
        if (halt_wake) begin
          d.mode = RMX_ST_RUN; // RQ11
          d.resume = 1'b1; // RQ12
        end
        // an nmi whose vector is missing from the table is fatal
        if (nmi_rise && !vec_in_table(RMX_VEC_NMI, ivt_limit_i)) begin
          d.mode = RMX_ST_SHUT; // RQ13
          d.resume = 1'b0;
        end else if (nmi_rise) begin
          d.exc.valid = 1'b1; // RQ18
          d.exc.vector = RMX_VEC_NMI;
          d.exc.fault = 1'b0;
        end
      end
      RMX_ST_SHUT: begin
        if (shut_wake) begin
          d.mode = RMX_ST_RUN; // RQ15
          d.exc.valid = 1'b1;
          d.exc.vector = RMX_VEC_NMI;
          d.exc.fault = 1'b0;
        end
      end
      default: d.mode = RMX_ST_SHUT;
    endcase
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0; // RQ1
      q.mode <= RMX_ST_RUN;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign real_mode_o = 1'b1; // RQ1
  assign op32_o = opsize_override_i; // RQ2
  assign phys_addr_o = q.phys;
  // halt and shutdown both release the local bus
  assign bus_enable_o = (q.mode == RMX_ST_RUN); // RQ11
  // lock covers only the cycle in which the locked form issues
  assign bus_lock_o = instr_valid_i && lock_prefix_i && lock_ok &&
                      (q.mode == RMX_ST_RUN); // RQ8
  assign exc_o = q.exc;
  assign resume_after_halt_o = q.resume;
  assign halted_o = (q.mode == RMX_ST_HALT);
  assign shutdown_o = (q.mode == RMX_ST_SHUT);

  // --------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------
  // the former drives 32 lines from a 21-bit sum of a shifted segment
  if (RMX_PA_W != 32 || RMX_SEG_SHIFT != 4) begin : g_bad_addr
    $error("rmx_ctrl needs a 32-bit address and a shift of four");
  end
  // the table check scales vectors by four bytes
  if (RMX_IVT_ENTRY_BYTES != 16'h0004) begin : g_bad_ivt
    $error("rmx_ctrl needs four-byte vector entries");
  end
endmodule : rmx_ctrl
`default_nettype wire

/* dv/rmx_ctrl_props.sv */
// port checker for rmx_ctrl
// assumes bind onto rmx_ctrl, names match its ports
`timescale 1ns/100ps
`default_nettype none
module rmx_ctrl_props
  import rmx_pkg::*;
(
  // inputs
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic lock_prefix_i,
  input wire rmx_op_e op_class_i,
  input wire logic mem_dest_i,
  input wire logic opsize_override_i,
  input wire logic ref_valid_i,
  input wire rmx_ref_s ref_i,
  input wire logic stack_push_i,
  input wire logic [15:0] stack_pointer_i,
  // outputs
  input wire logic real_mode_o,
  input wire logic op32_o,
  input wire logic [RMX_PA_W-1:0] phys_addr_o,
  input wire logic bus_enable_o,
  input wire logic halted_o,
  input wire logic shutdown_o,
  input wire rmx_exc_s exc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic run;
  logic legal;
  assign run = !halted_o && !shutdown_o;
  assign legal = op_class_i == RMX_OP_EXCHANGE || mem_dest_i &&
    op_class_i inside {RMX_OP_BT_MOD, RMX_OP_ALU, RMX_OP_UNARY};
  a_real_mode: assert property (real_mode_o)
    else $error("not real mode");
  a_op_size: assert property (op32_o == opsize_override_i)
    else $error("operand size");
  // code fetches excluded: upper lines stay high before far transfer
  a_phys_form: assert property (ref_valid_i && run && !ref_i.is_code &&
    ref_i.ea < 32'h10000 |=> phys_addr_o ==
    ({16'h0000, $past(ref_i.seg)} << 4) + $past(ref_i.ea))
    else $error("physical address");
  a_bad_lock: assert property (instr_valid_i && run && lock_prefix_i
    && !legal |=> exc_o.valid && exc_o.vector == RMX_VEC_UD)
    else $error("lock not refused");
  a_no_prot_exc: assert property (exc_o.valid |->
    !(exc_o.vector inside {8'h0A, 8'h0B, 8'h0E}))
    else $error("protected exception");
  a_halt_bus: assert property (halted_o |-> !bus_enable_o)
    else $error("bus used in halt");
  a_push_wrap: assert property (stack_push_i && run &&
    stack_pointer_i == 16'h0001 |=> shutdown_o)
    else $error("no shutdown");
  a_seg_wrap: assert property (ref_valid_i && run && !ref_i.is_stack &&
    ref_i.ea + ref_i.size_m1 > 32'hFFFF |=> exc_o.valid &&
    exc_o.vector == RMX_VEC_GP && exc_o.fault)
    else $error("no overrun");
  c_halt_exit: cover property (halted_o ##1 !halted_o);
  c_shut: cover property (shutdown_o ##1 !shutdown_o);
  c_lock: cover property (exc_o.valid && exc_o.vector == RMX_VEC_UD);
endmodule : rmx_ctrl_props
bind rmx_ctrl rmx_ctrl_props u_props (.*);
`default_nettype wire

/* dv/rmx_irq_src.sv */
// interrupt pin model: nmi and maskable request levels
// assumes one-cycle nmi requests from the bench
`timescale 1ns/100ps
`default_nettype none
module rmx_irq_src (
  // control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic nmi_req_i,
  input wire logic irq_req_i,
  // pins
  output logic nmi_o,
  output logic maskable_interrupt_request_o
);
  logic [3:0] cnt_q;
  // stretched so the three-flop synchroniser sees it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_q <= 4'h0;
    else if (nmi_req_i) cnt_q <= 4'h8;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign nmi_o = cnt_q != 4'h0;
  assign maskable_interrupt_request_o = irq_req_i;
endmodule : rmx_irq_src
`default_nettype wire

/* dv/rmx_tb.sv */
// self-checking bench for rmx_ctrl
// assumes rmx_pkg, rmx_irq_src and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench
  import rmx_pkg::*;
;
  logic clk_i = 0, rst_n_i = 0, instr_valid_i = 0, halt_instruction_i = 0;
  logic far_transfer_i = 0, lock_prefix_i = 0, mem_dest_i = 0;
  logic opsize_override_i = 0, ref_valid_i = 0, soft_int_i = 0;
  logic stack_push_i = 0, if_flag_i = 0, nmi_req = 0, irq_req = 0;
  logic resumed = 0, locked = 0;
  logic [1:0] io_privilege_level_i = 2'h3;
  logic [7:0] soft_vec_i = 8'h10;
  logic [15:0] stack_pointer_i = 16'h0100, ivt_limit_i = 16'h03FF;
  rmx_op_e op_class_i = RMX_OP_OTHER;
  rmx_ref_s ref_i = '0;
  logic nmi_i, maskable_interrupt_request_i, real_mode_o, op32_o;
  logic bus_enable_o, bus_lock_o, resume_after_halt_o, halted_o, shutdown_o;
  logic [RMX_PA_W-1:0] phys_addr_o;
  rmx_exc_s exc_o;
  int n_mismatch = 0, checks = 0;
  rmx_ctrl uut (.*);
  rmx_irq_src u_src (.clk_i, .rst_n_i, .nmi_req_i(nmi_req),
    .irq_req_i(irq_req), .nmi_o(nmi_i),
    .maskable_interrupt_request_o(maskable_interrupt_request_i));
  task automatic fin;
    @(posedge clk_i);
    instr_valid_i <= 0;
    ref_valid_i <= 0;
    soft_int_i <= 0;
    stack_push_i <= 0;
    #1;
  endtask : fin
  task automatic ins(logic h, logic l, rmx_op_e op, logic md);
    @(posedge clk_i);
    instr_valid_i <= 1;
    halt_instruction_i <= h;
    lock_prefix_i <= l;
    op_class_i <= op;
    mem_dest_i <= md;
    #1;
    locked = bus_lock_o;
    fin();
  endtask : ins
  task automatic mref(logic [15:0] s, logic [31:0] e, logic [1:0] z, logic k,
                      logic c = 0);
    @(posedge clk_i);
    ref_valid_i <= 1;
    ref_i <= '{s, e, z, k, c};
    fin();
  endtask : mref
  // waits a bounded span for halt or shutdown to end
  task automatic wake(logic n);
    @(posedge clk_i);
    nmi_req <= n;
    #1;
    resumed = resume_after_halt_o;
    @(posedge clk_i);
    nmi_req <= 0;
    #1;
    resumed |= resume_after_halt_o;
    for (int i = 0; i < 12 && (halted_o || shutdown_o); i++) begin
      @(posedge clk_i);
      #1;
      resumed |= resume_after_halt_o;
    end
  endtask : wake
  task automatic t_addr;
    `CHK("real_mode", 1'b1, real_mode_o)
    `CHK("op32", 1'b0, op32_o)
    mref(16'h1234, 32'h5, 2'h0, 0);
    `CHK("phys", 32'h00012345, phys_addr_o)
    mref(16'h1234, 32'h5, 2'h0, 0, 1);
    `CHK("code_hi", 32'hFFF12345, phys_addr_o)
    far_transfer_i <= 1;
    ins(0, 0, RMX_OP_OTHER, 0);
    far_transfer_i <= 0;
    mref(16'h1234, 32'h5, 2'h0, 0, 1);
    `CHK("code_lo", 32'h00012345, phys_addr_o)
    mref(16'hFFFF, 32'hFFFF, 2'h0, 0);
    `CHK("phys_top", 32'h0010FFEF, phys_addr_o)
    `CHK("no_exc", 1'b0, exc_o.valid)
    mref(16'h0000, 32'hFFFF, 2'h1, 0);
    `CHK("gp", {1'b1, RMX_VEC_GP, 1'b1}, exc_o)
    mref(16'h0000, 32'hFFFF, 2'h1, 1);
    `CHK("ss", {1'b1, RMX_VEC_SS, 1'b1}, exc_o)
    $display("t_addr done");
  endtask : t_addr
  task automatic t_lock;
    rmx_op_e ops[6] = '{RMX_OP_OTHER, RMX_OP_BT_MOD, RMX_OP_EXCHANGE,
      RMX_OP_ALU, RMX_OP_UNARY, RMX_OP_STRING};
    logic [5:0] ok = 6'b011110;
    foreach (ops[i]) begin
      io_privilege_level_i <= i[1:0];
      ins(0, 1, ops[i], 1);
      `CHK("lock", !ok[i], exc_o.valid)
      `CHK("bus_lock", ok[i], locked)
    end
    ins(0, 1, RMX_OP_ALU, 0);
    `CHK("lock_src", RMX_VEC_UD, exc_o.vector)
    $display("t_lock done");
  endtask : t_lock
  task automatic t_vec;
    @(posedge clk_i);
    ivt_limit_i <= 16'h0027;
    soft_int_i <= 1;
    fin();
    `CHK("df", {1'b1, RMX_VEC_DF, 1'b1}, exc_o)
    @(posedge clk_i);
    ivt_limit_i <= 16'h0017;
    soft_int_i <= 1;
    fin();
    `CHK("shut_df", 1'b1, shutdown_o)
    wake(1);
    `CHK("shut_exit", 1'b0, shutdown_o)
    `CHK("shut_resume", 1'b0, resumed)
    ivt_limit_i <= 16'h03FF;
    $display("t_vec done");
  endtask : t_vec
  task automatic t_halt;
    ins(1, 0, RMX_OP_OTHER, 0);
    `CHK("bus_off", 1'b0, bus_enable_o)
    irq_req <= 1;
    wake(0);
    `CHK("masked", 1'b1, halted_o)
    `CHK("masked_resume", 1'b0, resumed)
    if_flag_i <= 1;
    wake(0);
    `CHK("irq_wake", 1'b0, halted_o)
    `CHK("irq_resume", 1'b1, resumed)
    irq_req <= 0;
    if_flag_i <= 0;
    ins(1, 0, RMX_OP_OTHER, 0);
    wake(1);
    `CHK("nmi_wake", 1'b0, halted_o)
    `CHK("nmi_resume", 1'b1, resumed)
    $display("t_halt done");
  endtask : t_halt
  task automatic t_shut;
    @(posedge clk_i);
    stack_pointer_i <= 16'h0001;
    stack_push_i <= 1;
    fin();
    `CHK("wrap", 1'b1, shutdown_o)
    stack_pointer_i <= 16'h0005;
    wake(1);
    `CHK("stuck", 1'b1, shutdown_o)
    rst_n_i <= 0;
    fin();
    `CHK("reset_exit", 1'b0, shutdown_o)
    rst_n_i <= 1;
    $display("t_shut done");
  endtask : t_shut
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge clk_i);
    #1;
    t_addr();
    t_lock();
    t_vec();
    t_halt();
    t_shut();
    summarize();
  end
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
